// >>> rtl/psg_pkg.sv
package psg_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DIVSEL = 8'h04;
  localparam logic [7:0] ADDR_FRAC   = 8'h08;
  localparam logic [7:0] ADDR_SEED   = 8'h0c;
  localparam logic [7:0] ADDR_FREF   = 8'h10;
  localparam logic [7:0] ADDR_DELAY  = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PHASE  = 8'h1c;

  // ctrl fields
  localparam int CTRL_SYNC_BIT   = 0;
  localparam int CTRL_IGNORE_BIT = 1;
  localparam int CTRL_MODRST_BIT = 2;
  localparam int CTRL_ORDER_LSB  = 4;

  // output source codes
  localparam logic [1:0] SRC_CHANNEL_DIVISION  = 2'h0;
  localparam logic [1:0] SRC_VCO    = 2'h1;
  localparam logic [1:0] SRC_FREF   = 2'h2;

  // delay table constants
  localparam logic [5:0] DELAY_WEIGHT_SUM = 6'h3f;
  localparam logic [7:0] DELAY_CODE_MAX   = 8'hf7;
  localparam logic [5:0] DW1_MIN          = 6'h24;
  localparam logic [5:0] DW2_MIN          = 6'h1b;
  localparam int         DELAY_STEP_PS    = 9;

  localparam logic [3:0] PULSE_CNT_RST = 4'h4;
  localparam logic [3:0] INCL_ONE      = 4'h1;
  localparam int         DEG_FULL      = 360;

  typedef struct packed {
    logic [1:0] prescaler;    // 0:1 1:2 2:4
    logic       repeater;
    logic       pulsed;
    logic [3:0] pulse_cnt;
    logic [10:0] divider;
    logic       enable;
  } psg_fref_cfg_t;

  typedef struct packed {
    logic [5:0] w1;
    logic [5:0] w2;
    logic [5:0] w3;
    logic [5:0] w4;
  } psg_delay_t;

endpackage

// >>> rtl/psg_fref_gen.sv
`timescale 1ns/1ns
module psg_fref_gen (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  // control
  input  wire psg_pkg::psg_fref_cfg_t cfg_i,
  input  wire logic                   req_i,
  // output
  output logic                        fref_o,
  output logic                        busy_o
);

  logic [2:0]  pre_cnt_r;
  logic [2:0]  pre_cnt_nxt;
  logic [12:0] half_cnt_r;
  logic [12:0] half_cnt_nxt;
  logic [3:0]  pulses_left_r;
  logic        req_d_r;
  logic        out_r;
  logic        run_r;

  wire [2:0]  pre_max  = (cfg_i.prescaler == 2'h0) ? 3'h0 : (cfg_i.prescaler == 2'h1) ? 3'h1 : 3'h3;
  wire        interp   = (pre_cnt_r == pre_max);
  // half period in interpolator ticks is 2*divider+4: divider code 0 means divide by 8
  wire [12:0] half_max = {1'b0, cfg_i.divider, 1'b0} + 13'h0003;
  wire        half_end = interp && (half_cnt_r == half_max);
  wire        req_edge = interp && (req_i != req_d_r);
  wire        rise_req = req_edge && req_i;
  wire        fall_end = half_end && out_r;

  assign pre_cnt_nxt  = interp ? 3'h0 : pre_cnt_r + 3'h1;
  assign half_cnt_nxt = (half_end || !run_r) ? 13'h0000 : (interp ? half_cnt_r + 13'h0001 : half_cnt_r);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_cnt_r     <= 3'h0;
      half_cnt_r    <= 13'h0000;
      pulses_left_r <= 4'h0;
      req_d_r       <= 1'b0;
      out_r         <= 1'b0;
      run_r         <= 1'b0;
    end else begin
      pre_cnt_r  <= pre_cnt_nxt;
      half_cnt_r <= half_cnt_nxt;
      if (interp) begin
        req_d_r <= req_i;   // both edges retimed on the interpolator tick
      end
      if (!cfg_i.enable) begin
        out_r <= 1'b0;
        run_r <= 1'b0;
      end else if (cfg_i.repeater) begin
        if (req_edge) begin
          out_r <= req_i;   // echo the request
        end
        run_r <= 1'b0;
      end else if (!run_r) begin
        out_r <= 1'b0;
        if (rise_req && (!cfg_i.pulsed || cfg_i.pulse_cnt != 4'h0)) begin
          run_r         <= 1'b1;
          pulses_left_r <= cfg_i.pulse_cnt;
        end
      end else if (half_end) begin
        out_r <= ~out_r;
        if (fall_end && cfg_i.pulsed) begin
          pulses_left_r <= pulses_left_r - 4'h1;
          if (pulses_left_r == 4'h1) begin
            run_r <= 1'b0;
          end
        end
      end else if (!req_i && !cfg_i.pulsed && !out_r) begin
        run_r <= 1'b0;      // continuous stream stops when request drops
      end
    end
  end

  assign fref_o = out_r;
  assign busy_o = run_r;

  pulse_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (run_r && cfg_i.pulsed && fall_end && pulses_left_r == 4'h1) |=> !run_r)
    else $error("pulse series did not end on count");
  repeat_echo_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_i.enable && cfg_i.repeater && req_edge) |=> (out_r == $past(req_i)))
    else $error("repeater output did not follow request");
  half_period_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (run_r && half_end && !cfg_i.repeater && cfg_i.enable) |=> (out_r != $past(out_r)) || !run_r)
    else $error("divided output failed to toggle");

endmodule

// >>> rtl/psg_top.sv
`timescale 1ns/1ns
// What this block does
// - software 0-to-1 mode toggle makes sync
// - included division one, else twice segment
// - initial write of one is no sync
// - category two: toggle or pin edge
// - sync or modulator reset zeroes phase
// - seed writes accumulate phase offset
// - phase is 360*seed/den*incl/channel_division
// - zero numerator needs order above zero
// - interpolator is vco over division, prescaler
// - retime both request edges on interpolator
// - master mode divides by 4*divider+8
// - single, counted, or continuous pulses
// - four weight words form delay code
// - pin sync retimed to reference rising edge
// - repeater mode echoes request pin
module psg_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // pins
  input  wire logic        reference_osc_input_i,
  input  wire logic        sync_pin_i,
  input  wire logic        frame_ref_request_pin_i,
  // outputs
  output logic             sync_pulse_o,
  output logic             frame_ref_o,
  output logic [3:0]       feedback_included_division_o,
  output logic [7:0]       frame_ref_delay_code_o,
  output logic             delay_invalid_o
);

  // control registers
  logic        phase_sync_mode_bit_r;
  logic        sync_pin_disregard_r;
  logic        modulator_reset_n_r;
  logic [1:0]  modulator_order_r;
  logic [1:0]  output_a_source_r;
  logic [1:0]  output_b_source_r;
  logic [1:0]  second_divider_segment_r;
  logic [8:0]  channel_division_r;
  logic [15:0] fraction_denominator_r;
  logic [15:0] fraction_numerator_r;
  logic [15:0] modulator_seed_word_r;
  logic [31:0] phase_acc_r;
  logic [31:0] phase_acc_nxt;
  psg_pkg::psg_fref_cfg_t fref_cfg_r;
  psg_pkg::psg_delay_t    delay_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        sync_out_r;
  logic [7:0]  sync_events_r;

  // pin synchronisers
  logic [1:0] osc_sync_r;
  logic [1:0] spin_sync_r;
  logic [1:0] freq_sync_r;
  logic       osc_d_r;
  logic       spin_d_r;
  logic       spin_pend_r;
  logic       mode_d_r;
  logic       mode_armed_r;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // apb decode
  wire        access    = psel_i && penable_i && !pready_r;
  wire        wr_en     = access && pwrite_i;
  wire        rd_en     = access && !pwrite_i;
  wire        hit_ctrl  = (paddr_i == psg_pkg::ADDR_CTRL);
  wire        hit_div   = (paddr_i == psg_pkg::ADDR_DIVSEL);
  wire        hit_frac  = (paddr_i == psg_pkg::ADDR_FRAC);
  wire        hit_seed  = (paddr_i == psg_pkg::ADDR_SEED);
  wire        hit_fref  = (paddr_i == psg_pkg::ADDR_FREF);
  wire        hit_dly   = (paddr_i == psg_pkg::ADDR_DELAY);
  wire        hit_stat  = (paddr_i == psg_pkg::ADDR_STATUS);
  wire        hit_phase = (paddr_i == psg_pkg::ADDR_PHASE);
  wire        mapped    = hit_ctrl | hit_div | hit_frac | hit_seed | hit_fref | hit_dly | hit_stat | hit_phase;
  wire        wr_ro     = pwrite_i && (hit_stat || hit_phase);
  wire [31:0] ctrl_rd   = {24'h000000, 2'h0, modulator_order_r, 1'b0, modulator_reset_n_r,
                           sync_pin_disregard_r, phase_sync_mode_bit_r};
  wire [31:0] div_rd    = {15'h0000, channel_division_r, 2'h0, second_divider_segment_r,
                           output_b_source_r, output_a_source_r};
  wire [31:0] frac_rd   = {fraction_numerator_r, fraction_denominator_r};
  wire [31:0] fref_rd   = {12'h000, fref_cfg_r};
  wire [31:0] dly_rd    = {8'h00, delay_r};
  wire [31:0] ctrl_m    = merge_bytes(ctrl_rd, pwdata_i, pstrb_i);
  wire [31:0] div_m     = merge_bytes(div_rd, pwdata_i, pstrb_i);
  wire [31:0] frac_m    = merge_bytes(frac_rd, pwdata_i, pstrb_i);
  wire [31:0] fref_m    = merge_bytes(fref_rd, pwdata_i, pstrb_i);
  wire [31:0] dly_m     = merge_bytes(dly_rd, pwdata_i, pstrb_i);
  wire [31:0] seed_m    = merge_bytes({16'h0000, modulator_seed_word_r}, pwdata_i, pstrb_i);

  // included division
  wire channel_division_used = (output_a_source_r == psg_pkg::SRC_CHANNEL_DIVISION) || (output_b_source_r == psg_pkg::SRC_CHANNEL_DIVISION)
                    || (output_b_source_r == psg_pkg::SRC_FREF);
  wire [3:0] incl_div = (!phase_sync_mode_bit_r || !channel_division_used) ? psg_pkg::INCL_ONE
                        : {1'b0, second_divider_segment_r, 1'b0};

  // sync events
  wire osc_rise   = osc_sync_r[1] && !osc_d_r;
  wire spin_rise  = spin_sync_r[1] && !spin_d_r;
  wire pin_arm    = phase_sync_mode_bit_r && !sync_pin_disregard_r;
  // only a 1-0-1 toggle counts; the first write of one is setup
  wire mode_rise  = phase_sync_mode_bit_r && !mode_d_r && mode_armed_r;
  wire sync_event = osc_rise && (mode_rise || spin_pend_r);
  wire mod_reset  = !modulator_reset_n_r;
  wire seed_wr    = wr_en && hit_seed;

  // accumulated seed, zeroed by sync or modulator reset
  assign phase_acc_nxt = (sync_event || mod_reset) ? 32'h00000000
                         : seed_wr ? phase_acc_r + {16'h0000, seed_m[15:0]}
                         : phase_acc_r;

  // phase in degrees: acc*360*incl / (den*channel_division), for readback
  wire [47:0] ph_num   = 48'(phase_acc_r) * 48'(psg_pkg::DEG_FULL) * 48'(incl_div);
  wire [24:0] ph_den   = 25'(fraction_denominator_r) * 25'(channel_division_r);
  // first order only shifts on whole multiples of the denominator
  wire        ph_frac  = (fraction_denominator_r != 16'h0000) && (phase_acc_r % 32'(fraction_denominator_r) != 0);
  wire        ph_valid = (modulator_order_r != 2'h0) && !(modulator_order_r == 2'h1 && ph_frac);
  wire [15:0] ph_deg   = (ph_den == 25'h0 || !ph_valid) ? 16'h0000 : 16'(ph_num / 48'(ph_den));

  // delay code from weights
  wire [6:0] wsum = 7'(delay_r.w1) + 7'(delay_r.w2) + 7'(delay_r.w3) + 7'(delay_r.w4);
  function automatic logic [7:0] delay_code(input psg_pkg::psg_delay_t d);
    logic [7:0] c;
    c = 8'h00;
    if (d.w4 != 6'h00 && d.w2 == 6'h00) begin
      c = (d.w1 != 6'h00) ? 8'ha2 + 8'(d.w1) : 8'h63 + 8'(d.w4);
    end else if (d.w3 != 6'h00) begin
      c = 8'h24 + 8'(d.w3);
    end else if (d.w1 <= psg_pkg::DW1_MIN) begin
      c = 8'(psg_pkg::DW1_MIN - d.w1);
    end else begin
      c = 8'he1 + 8'(6'h3f - d.w1);
    end
    return c;
  endfunction
  wire [7:0] dcode   = delay_code(delay_r);
  wire       dbad    = (wsum != 7'(psg_pkg::DELAY_WEIGHT_SUM)) || (dcode > psg_pkg::DELAY_CODE_MAX);

  wire [31:0] stat_rd = {8'h00, sync_events_r, dcode, 2'h0, delay_invalid_o, frame_ref_o, incl_div};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd : hit_div ? div_rd : hit_frac ? frac_rd
                        : hit_seed ? {16'h0000, modulator_seed_word_r} : hit_fref ? fref_rd
                        : hit_dly ? dly_rd : hit_stat ? stat_rd : hit_phase ? {16'h0000, ph_deg} : 32'h00000000;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= access;
      pslverr_r <= access && (!mapped || wr_ro);
      prdata_r  <= (rd_en && mapped) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_sync_mode_bit_r    <= 1'b0;
      sync_pin_disregard_r     <= 1'b1;
      modulator_reset_n_r      <= 1'b1;
      modulator_order_r        <= 2'h0;
      output_a_source_r        <= psg_pkg::SRC_VCO;
      output_b_source_r        <= psg_pkg::SRC_VCO;
      second_divider_segment_r <= 2'h2;
      channel_division_r       <= 9'h002;
      fraction_denominator_r   <= 16'h0001;
      fraction_numerator_r     <= 16'h0000;
      modulator_seed_word_r    <= 16'h0000;
      fref_cfg_r               <= '{prescaler: 2'h0, repeater: 1'b0, pulsed: 1'b0,
                                    pulse_cnt: psg_pkg::PULSE_CNT_RST, divider: 11'h000, enable: 1'b0};
      delay_r                  <= '{w1: psg_pkg::DW1_MIN, w2: psg_pkg::DW2_MIN, w3: 6'h00, w4: 6'h00};
    end else if (wr_en) begin
      if (hit_ctrl) begin
        phase_sync_mode_bit_r <= ctrl_m[psg_pkg::CTRL_SYNC_BIT];
        sync_pin_disregard_r  <= ctrl_m[psg_pkg::CTRL_IGNORE_BIT];
        modulator_reset_n_r   <= ctrl_m[psg_pkg::CTRL_MODRST_BIT];
        modulator_order_r     <= ctrl_m[psg_pkg::CTRL_ORDER_LSB +: 2];
      end
      if (hit_div) begin
        output_a_source_r        <= div_m[1:0];
        output_b_source_r        <= div_m[3:2];
        second_divider_segment_r <= div_m[5:4];
        channel_division_r       <= div_m[16:8];
      end
      if (hit_frac) begin
        fraction_denominator_r <= frac_m[15:0];
        fraction_numerator_r   <= frac_m[31:16];
      end
      if (hit_seed) begin
        modulator_seed_word_r <= seed_m[15:0];
      end
      if (hit_fref) begin
        fref_cfg_r <= fref_m[19:0];
      end
      if (hit_dly) begin
        delay_r <= dly_m[23:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_sync_r    <= 2'h0;
      spin_sync_r   <= 2'h0;
      freq_sync_r   <= 2'h0;
      osc_d_r       <= 1'b0;
      spin_d_r      <= 1'b0;
      spin_pend_r   <= 1'b0;
      mode_d_r      <= 1'b0;
      mode_armed_r  <= 1'b0;
      sync_out_r    <= 1'b0;
      sync_events_r <= 8'h00;
      phase_acc_r   <= 32'h00000000;
    end else begin
      osc_sync_r  <= {osc_sync_r[0], reference_osc_input_i};
      spin_sync_r <= {spin_sync_r[0], sync_pin_i};
      freq_sync_r <= {freq_sync_r[0], frame_ref_request_pin_i};
      osc_d_r     <= osc_sync_r[1];
      spin_d_r    <= spin_sync_r[1];
      phase_acc_r <= phase_acc_nxt;
      // pending pin edge waits for the next reference rise; set wins over clear
      if (spin_rise && pin_arm) begin
        spin_pend_r <= 1'b1;
      end else if (osc_rise || !pin_arm) begin
        spin_pend_r <= 1'b0;
      end
      if (osc_rise) begin
        mode_d_r <= phase_sync_mode_bit_r;
      end else if (!phase_sync_mode_bit_r) begin
        mode_d_r <= 1'b0;
      end
      if (mode_d_r && !phase_sync_mode_bit_r) begin
        mode_armed_r <= 1'b1;
      end
      sync_out_r <= sync_event;
      if (sync_event) begin
        sync_events_r <= sync_events_r + 8'h01;
      end
    end
  end

  psg_fref_gen u_fref (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .cfg_i     (fref_cfg_r),
    .req_i     (freq_sync_r[1]),
    .fref_o    (frame_ref_o),
    .busy_o    ()
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      feedback_included_division_o <= psg_pkg::INCL_ONE;
      frame_ref_delay_code_o       <= 8'h00;
      delay_invalid_o              <= 1'b0;
    end else begin
      feedback_included_division_o <= incl_div;
      frame_ref_delay_code_o       <= dcode;
      delay_invalid_o              <= dbad;
    end
  end

  assign prdata_o     = prdata_r;
  assign pready_o     = pready_r;
  assign pslverr_o    = pslverr_r;
  assign sync_pulse_o = sync_out_r;

  sync_single_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync_out_r |=> !sync_out_r)
    else $error("sync pulse longer than one cycle");
  sync_on_ref_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync_out_r |-> $past(osc_rise))
    else $error("sync not aligned to reference rise");
  phase_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (sync_event || mod_reset) |=> (phase_acc_r == 32'h00000000))
    else $error("phase not cleared by sync");
  seed_accum_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (seed_wr && !sync_event && !mod_reset) |=> (phase_acc_r == $past(phase_acc_r) + {16'h0000, $past(seed_m[15:0])}))
    else $error("seed write did not accumulate");
  incl_div_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (phase_sync_mode_bit_r && channel_division_used) |-> (incl_div == {1'b0, second_divider_segment_r, 1'b0}))
    else $error("included division wrong");
  sync_needs_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync_event |-> phase_sync_mode_bit_r)
    else $error("sync event without mode bit");
  apb_ready_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (psel_i && penable_i && !pready_r) |=> pready_r)
    else $error("apb access not answered next cycle");
  delay_check_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wsum != 7'(psg_pkg::DELAY_WEIGHT_SUM)) |=> delay_invalid_o)
    else $error("bad weight sum not flagged");

endmodule

// >>> testbench/psg_pin_model.sv
`timescale 1ns/1ns
module psg_pin_model (
  // clock
  input  wire logic clk_i,
  // command from bench
  input  wire logic sync_go_i,
  // pins
  output logic      ref_o,
  output logic      sync_o
);
  logic [1:0] div_r;
  initial begin
    div_r  = 2'h0;
    ref_o  = 1'b0;
    sync_o = 1'b0;
  end
  // slow reference, 8 clocks a period, well under the pin-sync ceiling
  always @(posedge clk_i) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3) ref_o <= ~ref_o;
  end
  // setup is category two, never four; calibration not modelled
  // sync edges only mid-low phase, away from reference rise
  always @(posedge clk_i) begin
    if (div_r == 2'h1 && !ref_o) sync_o <= sync_go_i;
  end
endmodule

// >>> testbench/psg_top_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module psg_top_tb_top;
  logic        clk_i, sys_rst_i, psel, penable, pwrite, sync_go, req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_o;
  logic        pready_o, pslverr_o, ref_w, sync_w, sync_pulse_o, frame_ref_o, delay_invalid_o, fr_d;
  logic [3:0]  incl_o;
  logic [7:0]  code_o;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          err_count, check_count, sync_cnt, fr_cnt, since, gap, n, n0;
  logic [23:0] dtab[8] = '{{6'd36, 6'd27, 6'd0, 6'd0}, {6'd0, 6'd63, 6'd0, 6'd0}, {6'd0, 6'd0, 6'd63, 6'd0},
    {6'd0, 6'd0, 6'd0, 6'd63}, {6'd63, 6'd0, 6'd0, 6'd0}, {6'd41, 6'd22, 6'd0, 6'd0}, {6'd1, 6'd1, 6'd0, 6'd0},
    {6'd35, 6'd28, 6'd0, 6'd0}};
  logic [8:0]  dexp[8] = '{9'h000, 9'h024, 9'h063, 9'h0a2, 9'h0e1, 9'h0f7, 9'h100, 9'h001};
  logic [5:0]  itab[4] = '{6'h25, 6'h24, 6'h39, 6'h21};
  logic [3:0]  iexp[4] = '{4'h1, 4'h4, 4'h6, 4'h4};

  psg_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .reference_osc_input_i(ref_w), .sync_pin_i(sync_w),
    .frame_ref_request_pin_i(req), .sync_pulse_o(sync_pulse_o), .frame_ref_o(frame_ref_o),
    .feedback_included_division_o(incl_o), .frame_ref_delay_code_o(code_o), .delay_invalid_o(delay_invalid_o));
  psg_pin_model pins (.clk_i(clk_i), .sync_go_i(sync_go), .ref_o(ref_w), .sync_o(sync_w));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // w selects write; write results carry only the error flag
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({w, err, w ? 32'h0 : d});
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? d : 32'h0;
    @(posedge clk_i);
    penable <= 1'b1;
    @(negedge clk_i);
    while (pready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_clk(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // bus results looked at mid-cycle, where the one-cycle answer stands settled
  always @(negedge clk_i) begin
    if (pready_o === 1'b1) begin
      e = exp_q.pop_front();
      if (!e[33]) `CHK(prdata_o, e[31:0])
      `CHK(pslverr_o, e[32])
    end
  end

  always @(posedge clk_i) begin
    if (sync_pulse_o === 1'b1) sync_cnt++;
    fr_d <= frame_ref_o;
    since++;
    if (frame_ref_o === 1'b1 && fr_d === 1'b0) begin
      fr_cnt++;
      gap   = since;
      since = 0;
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, sync_go, req, fr_d} = '0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    sys_rst_i = 1'b1;
    void'($urandom(25498));
    wait_clk(5);
    sys_rst_i <= 1'b0;
    apb(0, psg_pkg::ADDR_CTRL, 32'h0000_0006, 0);
    apb(0, psg_pkg::ADDR_FREF, 32'h0000_4000, 0);
    apb(0, psg_pkg::ADDR_DELAY, 32'h0091_b000, 0);
    apb(0, 8'h20, 32'h0, 1);
    apb(1, psg_pkg::ADDR_STATUS, 32'h1, 1);
    `CHK(incl_o, 4'h1)
    `CHK(code_o, 8'h00)
    apb(1, psg_pkg::ADDR_CTRL, 32'h0000_0025, 0);
    for (int i = 0; i < 4; i++) begin
      apb(1, psg_pkg::ADDR_DIVSEL, {15'h0, 9'h008, 2'h0, itab[i]}, 0);
      wait_clk(3);
      `CHK(incl_o, iexp[i])
    end
    `CHK(sync_cnt, 0)
    apb(1, psg_pkg::ADDR_FRAC, 32'h0000_0004, 0);
    apb(1, psg_pkg::ADDR_SEED, 32'h1, 0);
    apb(0, psg_pkg::ADDR_PHASE, 32'd45, 0);
    apb(1, psg_pkg::ADDR_SEED, 32'h1, 0);
    apb(0, psg_pkg::ADDR_PHASE, 32'd90, 0);
    apb(1, psg_pkg::ADDR_CTRL, 32'h0000_0021, 0);
    apb(1, psg_pkg::ADDR_CTRL, 32'h0000_0025, 0);
    apb(0, psg_pkg::ADDR_PHASE, 32'd0, 0);
    apb(1, psg_pkg::ADDR_SEED, 32'h1, 0);
    n0 = sync_cnt;
    apb(1, psg_pkg::ADDR_CTRL, 32'h0000_0026, 0);
    apb(1, psg_pkg::ADDR_CTRL, 32'h0000_0025, 0);
    wait_clk(40);
    `CHK(sync_cnt - n0, 1)
    apb(0, psg_pkg::ADDR_PHASE, 32'd0, 0);
    n0 = sync_cnt;
    sync_go <= 1'b1;
    wait_clk(40);
    sync_go <= 1'b0;
    wait_clk(40);
    `CHK(sync_cnt - n0, 1)
    for (int i = 0; i < 8; i++) begin
      apb(1, psg_pkg::ADDR_DELAY, {8'h0, dtab[i]}, 0);
      wait_clk(3);
      `CHK(delay_invalid_o, dexp[i][8])
      if (!dexp[i][8]) `CHK(code_o, dexp[i][7:0])
    end
    // master mode, divider code 0, interpolator at clock rate
    apb(1, psg_pkg::ADDR_DIVSEL, 32'h0000_0829, 0);
    n = $urandom_range(5, 1);
    apb(1, psg_pkg::ADDR_FREF, 32'h0001_0001 | (n << 12), 0);
    n0 = fr_cnt;
    req <= 1'b1;
    wait_clk(300);
    `CHK(fr_cnt - n0, n)
    if (n > 1) `CHK(gap, 8)
    req <= 1'b0;
    wait_clk(10);
    end_sim();
  end
endmodule
